// >>> rtl/stcc_pkg.sv
// Package with register map, field layout and timing constants of the timing calibration control block.
`default_nettype none
package stcc_pkg;
  // ----------------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------------
  localparam logic [11:0] ADDR_SUPPLY_NOISE = 12'h2A2;
  localparam logic [11:0] ADDR_CAL_ENABLE   = 12'h2B0;
  localparam logic [11:0] ADDR_CAL_CONFIG   = 12'h2B1;
  localparam logic [11:0] ADDR_CAL_STATUS   = 12'h2B2;
  localparam logic [11:0] ADDR_DELAY_ADJ    = 12'h2B5;
  // ----------------------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  RST_SUPPLY_NOISE  = 8'h00;
  localparam logic [7:0]  RST_CAL_ENABLE    = 8'h00;
  localparam logic [7:0]  RST_CAL_CONFIG    = 8'h05;
  localparam logic [16:0] RST_DELAY_ADJ     = 17'h00000;
  localparam int          BIT_CAL_ENABLE    = 0;
  localparam int          BIT_CORE_SUPPR    = 5;
  localparam int          BIT_CLK_SUPPR     = 4;
  localparam int          AVG_LSB           = 2;
  localparam int          LEN_LSB           = 0;
  localparam int          BIT_DONE          = 17;
  localparam int          DELAY_W           = 17;
  // ----------------------------------------------------------------------------
  // Timing: bound = 384 * 19 * 4^(avg + len + 2) sample-clock cycles.
  // ----------------------------------------------------------------------------
  localparam int          BOUND_BASE        = 384 * 19;
  localparam int          POW_OFFSET        = 2;
  localparam int          CNT_W             = 32;
  // The start, engine state and status registers use up part of the budget, so the engine counts them off.
  localparam int          RUN_LATENCY       = 3;
  // ----------------------------------------------------------------------------
  // Longest SYSREF period each accumulation length code covers, in cycles
  // ----------------------------------------------------------------------------
  localparam logic [3:0][15:0] MAX_PERIOD   = {16'h7E80, 16'h1E80, 16'h0680, 16'h0080};
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } stcc_state_t;
endpackage
`default_nettype wire

// >>> rtl/stcc_cal_if.sv
// Interface carrying start, settings and result between control and engine.
`default_nettype none
interface stcc_cal_if;
  logic        start;
  logic [1:0]  avg_sel;
  logic [1:0]  len_sel;
  logic        done;
  logic [16:0] result;
  modport ctrl (output start, output avg_sel, output len_sel, input done, input result);
  modport eng  (input start, input avg_sel, input len_sel, output done, output result);
endinterface
`default_nettype wire

// >>> rtl/stcc_cal_engine.sv
// Calibration sequencer: runs for the bounded duration and yields a delay estimate.
`default_nettype none
module stcc_cal_engine #(
  parameter int CYCLE_BASE = stcc_pkg::BOUND_BASE
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  input  wire logic         i_sysref,
  stcc_cal_if.eng           cal
);
  stcc_pkg::stcc_state_t state_q;
  logic [stcc_pkg::CNT_W-1:0] cnt_q;
  logic [stcc_pkg::CNT_W-1:0] limit;
  logic [7:0]                 phase_q;
  logic [7:0]                 edge_ph_q;
  logic                       sysref_q;
  logic                       finish;
  logic [stcc_pkg::DELAY_W-1:0] result_q;

  // Cycle budget grows fourfold per code step, so a shift gives the exact bound.
  assign limit = stcc_pkg::CNT_W'(CYCLE_BASE)
                 << (2 * (cal.avg_sel + cal.len_sel + stcc_pkg::POW_OFFSET));
  // Stopping early by the register latency puts the status bit exactly on the bound.
  assign finish = (state_q == stcc_pkg::ST_RUN) && (cnt_q >= limit - stcc_pkg::RUN_LATENCY);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= stcc_pkg::ST_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        stcc_pkg::ST_IDLE: begin
          if (cal.start) begin
            state_q <= stcc_pkg::ST_RUN;
            cnt_q   <= '0;
          end
        end
        stcc_pkg::ST_RUN: begin
          cnt_q <= cnt_q + 1'b1;
          if (finish) state_q <= stcc_pkg::ST_DONE;
        end
        stcc_pkg::ST_DONE: begin
          if (cal.start) begin
            state_q <= stcc_pkg::ST_RUN;
            cnt_q   <= '0;
          end
        end
        default: state_q <= stcc_pkg::ST_IDLE;
      endcase
    end
  end

  // The phase of the last SYSREF edge against a free count stands in for the measured offset.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sysref_q  <= 1'b0;
      phase_q   <= '0;
      edge_ph_q <= '0;
    end else begin
      sysref_q <= i_sysref;
      phase_q  <= phase_q + 1'b1;
      if (i_sysref && !sysref_q) edge_ph_q <= phase_q;
    end
  end

  // The estimate is frozen at completion so the applied delay cannot wander afterwards.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      result_q <= '0;
    end else if (finish) begin
      result_q <= {edge_ph_q[7], edge_ph_q, ~edge_ph_q};
    end
  end

  assign cal.done   = (state_q == stcc_pkg::ST_DONE);
  assign cal.result = result_q;
endmodule
`default_nettype wire

// >>> rtl/stcc_timing_cal_ctrl.sv
// Top of the timing calibration control block with its configuration registers.
`default_nettype none
module stcc_timing_cal_ctrl #(
  parameter int CYCLE_BASE = stcc_pkg::BOUND_BASE
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [11:0] i_reg_addr,
  input  wire logic [23:0] i_reg_wdata,
  input  wire logic        i_sysref,
  output var  logic [23:0] o_reg_rdata,
  output var  logic [16:0] o_sample_delay,
  output var  logic        o_core_rail_noise_suppress,
  output var  logic        o_clock_rail_noise_suppress,
  output var  logic        o_cal_complete_flag
);
  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  logic [7:0]  noise_q;
  logic [7:0]  enable_q;
  logic [7:0]  config_q;
  logic [16:0] manual_q;
  logic        start_q;
  logic        done_q;
  logic        en_new;
  logic [23:0] status;
  logic        sysref_q;
  logic [15:0] gap_q;
  logic [15:0] gap_max;
  logic        run_act;
  logic        fail_q;
  stcc_cal_if  cal ();

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      noise_q  <= stcc_pkg::RST_SUPPLY_NOISE;
      enable_q <= stcc_pkg::RST_CAL_ENABLE;
      config_q <= stcc_pkg::RST_CAL_CONFIG;
      manual_q <= stcc_pkg::RST_DELAY_ADJ;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        stcc_pkg::ADDR_SUPPLY_NOISE: noise_q  <= i_reg_wdata[7:0];
        stcc_pkg::ADDR_CAL_ENABLE:   enable_q <= i_reg_wdata[7:0];
        stcc_pkg::ADDR_CAL_CONFIG:   config_q <= i_reg_wdata[7:0];
        stcc_pkg::ADDR_DELAY_ADJ:    manual_q <= i_reg_wdata[16:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Start and completion
  // ----------------------------------------------------------------------------
  // Only a write that turns the bit on starts a run; rewriting 1 does nothing.
  assign en_new = i_reg_wr && (i_reg_addr == stcc_pkg::ADDR_CAL_ENABLE) &&
                  i_reg_wdata[stcc_pkg::BIT_CAL_ENABLE] && !enable_q[stcc_pkg::BIT_CAL_ENABLE];

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      start_q <= 1'b0;
    end else begin
      start_q <= en_new;
    end
  end

  // The engine's done is stale until it sees the start, so the flag is held low meanwhile.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      done_q <= 1'b0;
    end else if (en_new || start_q || !enable_q[stcc_pkg::BIT_CAL_ENABLE]) begin
      done_q <= 1'b0;
    end else begin
      done_q <= cal.done && !fail_q;
    end
  end

  // ----------------------------------------------------------------------------
  // SYSREF period watch
  // ----------------------------------------------------------------------------
  // The gap counter saturates, so a stopped SYSREF still reads as too long.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sysref_q <= 1'b0;
      gap_q    <= '0;
    end else begin
      sysref_q <= i_sysref;
      if (i_sysref && !sysref_q) begin
        gap_q <= 16'h0001;
      end else if (gap_q != '1) begin
        gap_q <= gap_q + 16'h0001;
      end
    end
  end

  assign gap_max = stcc_pkg::MAX_PERIOD[config_q[stcc_pkg::LEN_LSB +: 2]];
  assign run_act = enable_q[stcc_pkg::BIT_CAL_ENABLE] && !done_q;

  // A spoiled run shows done for one cycle only if its gap is first seen as the engine's done rises; a gap seen as a new run starts still counts against it.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      fail_q <= 1'b0;
    end else if (run_act && (gap_q > gap_max)) begin
      fail_q <= 1'b1;
    end else if (start_q) begin
      fail_q <= 1'b0;
    end
  end

  assign cal.start   = start_q;
  assign cal.avg_sel = config_q[stcc_pkg::AVG_LSB +: 2];
  assign cal.len_sel = config_q[stcc_pkg::LEN_LSB +: 2];

  stcc_cal_engine #(
    .CYCLE_BASE (CYCLE_BASE)
  ) u_engine (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_sysref  (i_sysref),
    .cal       (cal)
  );

  // ----------------------------------------------------------------------------
  // Outputs and read-back
  // ----------------------------------------------------------------------------
  assign status = {6'h00, done_q, done_q ? cal.result : 17'h00000};

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sample_delay <= stcc_pkg::RST_DELAY_ADJ;
    end else if (enable_q[stcc_pkg::BIT_CAL_ENABLE]) begin
      if (done_q) o_sample_delay <= cal.result;
    end else begin
      o_sample_delay <= manual_q;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_core_rail_noise_suppress  <= 1'b0;
      o_clock_rail_noise_suppress <= 1'b0;
      o_cal_complete_flag         <= 1'b0;
    end else begin
      o_core_rail_noise_suppress  <= noise_q[stcc_pkg::BIT_CORE_SUPPR];
      o_clock_rail_noise_suppress <= noise_q[stcc_pkg::BIT_CLK_SUPPR];
      o_cal_complete_flag         <= done_q;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        stcc_pkg::ADDR_SUPPLY_NOISE: o_reg_rdata <= {16'h0000, noise_q};
        stcc_pkg::ADDR_CAL_ENABLE:   o_reg_rdata <= {16'h0000, enable_q};
        stcc_pkg::ADDR_CAL_CONFIG:   o_reg_rdata <= {16'h0000, config_q};
        stcc_pkg::ADDR_CAL_STATUS:   o_reg_rdata <= status;
        stcc_pkg::ADDR_DELAY_ADJ:    o_reg_rdata <= {7'h00, manual_q};
        default:                     o_reg_rdata <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> testbench/stcc_sva.sv
// Checker for the timing calibration control block.
`default_nettype none
module stcc_sva #(
  parameter int BASE = stcc_pkg::BOUND_BASE
) (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [11:0] i_reg_addr,
  input wire logic [23:0] i_reg_wdata,
  input wire logic        i_sysref,
  input wire logic [23:0] o_reg_rdata,
  input wire logic [16:0] o_sample_delay,
  input wire logic        o_core_rail_noise_suppress,
  input wire logic        o_cal_complete_flag
);
  logic        en_q;
  logic [7:0]  cfg_q;
  logic [16:0] adj_q;
  logic [2:0]  qt_q;
  logic [31:0] cn_q;
  logic [31:0] bd_q;
  logic        sr_q;
  logic [15:0] gp_q;
  logic        bad_q;
  localparam logic [3:0][15:0] MAXP = {16'h7E80, 16'h1E80, 16'h0680, 16'h0080};
  wire d  = o_cal_complete_flag;
  wire we = i_reg_wr && i_reg_addr == stcc_pkg::ADDR_CAL_ENABLE;
  wire st = we && i_reg_wdata[0] && !en_q;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      en_q  <= 1'b0;
      cfg_q <= stcc_pkg::RST_CAL_CONFIG;
      adj_q <= '0;
    end else begin
      if (we) en_q <= i_reg_wdata[0];
      if (i_reg_wr && i_reg_addr == stcc_pkg::ADDR_CAL_CONFIG) cfg_q <= i_reg_wdata[7:0];
      if (i_reg_wr && i_reg_addr == stcc_pkg::ADDR_DELAY_ADJ) adj_q <= i_reg_wdata[16:0];
    end
  end
  // The delay output latency is open, so the manual check waits for quiet cycles.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      qt_q <= '0;
      cn_q <= '0;
      bd_q <= '0;
    end else begin
      qt_q <= i_reg_wr ? 3'h0 : (qt_q == 3'h7 ? qt_q : qt_q + 3'h1);
      cn_q <= st ? 32'h0 : cn_q + 32'h1;
      if (st) bd_q <= BASE << (2 * (cfg_q[3:2] + cfg_q[1:0] + 2));
    end
  end
  // A run that meets a SYSREF gap beyond its accumulation reach is marked spoiled.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sr_q  <= 1'b0;
      gp_q  <= '0;
      bad_q <= 1'b0;
    end else begin
      sr_q <= i_sysref;
      gp_q <= (i_sysref && !sr_q) ? 16'h1 : (gp_q == 16'hFFFF ? gp_q : gp_q + 16'h1);
      if (st) bad_q <= 1'b0;
      else if (en_q && !d && gp_q > MAXP[cfg_q[1:0]]) bad_q <= 1'b1;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence low_s; !d [*3]; endsequence
  core_supp_a: assert property (
    i_reg_wr && i_reg_addr == stcc_pkg::ADDR_SUPPLY_NOISE |-> ##2
    o_core_rail_noise_suppress == $past(i_reg_wdata[5], 2)) else $error("core suppress");
  done_clear_a: assert property (we && !i_reg_wdata[0] |-> ##3 !d) else $error("done clear");
  new_start_a: assert property (st |=> low_s) else $error("start clear");
  no_restart_a: assert property (we && i_reg_wdata[0] && en_q && d |=> d [*3]) else $error("restart");
  manual_dly_a: assert property (qt_q == 3'h7 && !en_q |-> o_sample_delay == adj_q) else $error("manual");
  auto_hold_a: assert property (en_q && d && $past(d) |-> $stable(o_sample_delay)) else $error("auto");
  status_rd_a: assert property (
    i_reg_rd && i_reg_addr == stcc_pkg::ADDR_CAL_STATUS && d |=>
    o_reg_rdata[17] && o_reg_rdata[16:0] == o_sample_delay) else $error("status");
  cfg_rd_a: assert property (
    i_reg_rd && i_reg_addr == stcc_pkg::ADDR_CAL_CONFIG |=>
    o_reg_rdata == {16'h0, $past(cfg_q)}) else $error("config");
  cal_bound_a: assert property (en_q && !d && !bad_q |-> cn_q <= bd_q) else $error("bound");
  fail_hold_a: assert property (bad_q |-> !d) else $error("spoiled run done");
endmodule
bind stcc_timing_cal_ctrl stcc_sva #(.BASE(CYCLE_BASE)) u_sva (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_reg_wr(i_reg_wr), .i_sysref(i_sysref),
  .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .o_sample_delay(o_sample_delay), .o_core_rail_noise_suppress(o_core_rail_noise_suppress),
  .o_cal_complete_flag(o_cal_complete_flag));
`default_nettype wire

// >>> testbench/stcc_sysref_src.sv
// Periodic SYSREF source model.
`default_nettype none
module stcc_sysref_src #(
  parameter int PERIOD = 64
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  output var  logic o_sysref
);
  logic [15:0] cnt_q;
  // The default period stays below the shortest limit of 128 cycles; a longer one provokes a spoiled run.
  always_ff @(negedge i_ref_clk or posedge i_rst) begin
    if (i_rst) cnt_q <= '0;
    else cnt_q <= (cnt_q == 16'(PERIOD - 1)) ? 16'h0 : cnt_q + 16'h1;
  end
  assign o_sysref = cnt_q < 16'(PERIOD / 2);
endmodule
`default_nettype wire

// >>> testbench/stcc_timing_cal_ctrl_bench.sv
// Self-checking bench for the timing calibration control block.
`default_nettype none
module stcc_timing_cal_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] AN = stcc_pkg::ADDR_SUPPLY_NOISE;
  localparam logic [11:0] AE = stcc_pkg::ADDR_CAL_ENABLE;
  localparam logic [11:0] AC = stcc_pkg::ADDR_CAL_CONFIG;
  localparam logic [11:0] AS = stcc_pkg::ADDR_CAL_STATUS;
  localparam logic [11:0] AD = stcc_pkg::ADDR_DELAY_ADJ;
  // A short cycle base keeps runs brief while the fourfold growth per code stays intact.
  localparam int          CB = 57;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr  = 1'b0;
  logic        rd  = 1'b0;
  logic        sr, sr_fast, sr_slow, cs, ks, fl;
  logic        slow = 1'b0;
  logic [11:0] ad  = 12'h0;
  logic [23:0] wd  = 24'h0;
  logic [23:0] rdat, v;
  logic [16:0] dly;
  int          err_count = 0;
  int          num_checks = 0;
  int          n;
  always #5 clk = ~clk;
  stcc_sysref_src src (.i_ref_clk(clk), .i_rst(rst), .o_sysref(sr_fast));
  stcc_sysref_src #(.PERIOD(200)) src_slow (.i_ref_clk(clk), .i_rst(rst), .o_sysref(sr_slow));
  assign sr = slow ? sr_slow : sr_fast;
  stcc_timing_cal_ctrl #(.CYCLE_BASE(CB)) dut (.i_ref_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(ad),
    .i_reg_wdata(wd), .i_sysref(sr), .o_reg_rdata(rdat), .o_sample_delay(dly),
    .o_core_rail_noise_suppress(cs), .o_clock_rail_noise_suppress(ks), .o_cal_complete_flag(fl));
  task automatic chk(input string nm, input logic [23:0] s, input logic [23:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [23:0] d);
    @(negedge clk);
    {wr, ad, wd} = {1'b1, a, d};
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, output logic [23:0] d);
    @(negedge clk);
    {rd, ad} = {1'b1, a};
    @(negedge clk);
    rd = 1'b0;
    d = rdat;
  endtask
  task automatic t_regs();
    chk("outs", {4'h0, cs, ks, fl, dly}, 24'h0);
    rd_reg(AC, v);
    chk("cfg", v, 24'h5);
    rd_reg(AE, v);
    chk("en", v, 24'h0);
    wr_reg(AN, 24'h20);
    @(negedge clk);
    chk("sup", {22'h0, cs, ks}, 24'h2);
    wr_reg(AN, 24'h1F);
    rd_reg(AN, v);
    chk("sup", {14'h0, v[7:0], cs, ks}, 24'h7D);
    wr_reg(AD, 24'h1ABCD);
    wr_reg(AS, 24'h3FFFF);
    rd_reg(AS, v);
    chk("ro", v, 24'h0);
    rd_reg(12'h2B3, v);
    chk("unmap", v, 24'h0);
    chk("dly", {7'h0, dly}, 24'h1ABCD);
    for (n = 0; n < 16; n++) begin
      wr_reg(AC, 24'(n));
      rd_reg(AC, v);
      chk("cfg", v, 24'(n));
    end
    $display("test regs done");
  endtask
  task automatic t_cal();
    wr_reg(AC, 24'h0);
    wr_reg(AE, 24'h1); // No background calibration runs here.
    chk("clr", {23'h0, fl}, 24'h0);
    n = 0;
    while (fl !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    // The flag output trails the status bit by one cycle.
    chk("bound", {23'h0, n <= CB * 16 + 1}, 24'h1);
    rd_reg(AS, v);
    chk("done", v, {7'h1, dly});
    v = {7'h0, dly};
    wr_reg(AD, 24'h55);
    wr_reg(AE, 24'h1);
    repeat (3) @(negedge clk);
    chk("auto", {6'h0, fl, dly}, {6'h0, 1'b1, v[16:0]});
    wr_reg(AE, 24'h0);
    repeat (3) @(negedge clk);
    chk("man", {6'h0, fl, dly}, 24'h55);
    wr_reg(AC, 24'h5);
    wr_reg(AE, 24'h1);
    repeat (3) @(negedge clk);
    chk("rerun", {23'h0, fl}, 24'h0);
    n = 0;
    while (fl !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk("bound5", {23'h0, n <= CB * 256 + 1}, 24'h1);
    $display("test cal done");
  endtask
  task automatic t_fail();
    slow = 1'b1;
    wr_reg(AE, 24'h0);
    wr_reg(AC, 24'h0);
    wr_reg(AE, 24'h1); // No background calibration runs here.
    repeat (CB * 16 + 8) @(negedge clk);
    rd_reg(AS, v);
    chk("fail", {16'h0, v[23:17], fl}, 24'h0);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    {rst, slow} = 2'b00;
    chk("rst", {6'h0, fl, dly}, 24'h0);
    rd_reg(AC, v);
    chk("cfg", v, 24'h5);
    $display("test fail done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_cal();
    t_fail();
    give_verdict();
  end
  initial begin
    #400000;
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
